// ==== rtl/lait_pkg.sv ====
// Package for the light converter integration timing block
package lait_pkg;
    localparam logic [7:0] LAIT_ADDR_CMD = 8'h00;
    localparam logic [7:0] LAIT_ADDR_CTRL = 8'h01;
    localparam logic [7:0] LAIT_ADDR_READ_LO = 8'h04;
    localparam logic [7:0] LAIT_ADDR_READ_HI = 8'h05;
    localparam logic [7:0] LAIT_ADDR_SNAP_LO = 8'h06;
    localparam logic [7:0] LAIT_ADDR_SNAP_HI = 8'h07;
    localparam int LAIT_SYNC_BIT = 7;
    localparam int LAIT_MODE_BIT = 5;
    localparam int LAIT_WIDTH_LSB = 0;
    localparam int LAIT_GAIN_LSB = 2;
    localparam logic [7:0] LAIT_CMD_RST = 8'h00;
    localparam logic [7:0] LAIT_CTRL_RST = 8'h00;
    localparam logic [15:0] LAIT_CNT_RST = 16'h0000;
    localparam logic [7:0] LAIT_RD_RST = 8'h00;
    localparam logic [1:0] LAIT_W_65536 = 2'h0;
    localparam logic [1:0] LAIT_W_4096 = 2'h1;
    localparam logic [1:0] LAIT_W_256 = 2'h2;
    localparam logic [1:0] LAIT_W_16 = 2'h3;
    localparam logic [15:0] LAIT_LAST_65536 = 16'hffff;
    localparam logic [15:0] LAIT_LAST_4096 = 16'h0fff;
    localparam logic [15:0] LAIT_LAST_256 = 16'h00ff;
    localparam logic [15:0] LAIT_LAST_16 = 16'h000f;

    typedef enum logic [1:0] {
        LAIT_EXT_IDLE = 2'b00,
        LAIT_EXT_ARR1 = 2'b01,
        LAIT_EXT_ARR2 = 2'b10
    } lait_ext_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } lait_wr_t;
endpackage

// ==== rtl/lait_osc_div.sv ====
// Oscillator tick generator with half speed on the low gain ranges
`timescale 1ns/1ps
module lait_osc_div
    import lait_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_half_speed,
    output logic o_tick
);
    typedef struct packed {
        logic phase;
    } lait_div_st_t;

    lait_div_st_t st_r;
    lait_div_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.phase = i_half_speed ? ~st_r.phase : 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Full speed ticks every clock; half speed every second one
    assign o_tick = i_half_speed ? st_r.phase : 1'b1;
endmodule

// ==== rtl/lait_top.sv ====
// Integration timing and result capture for the light converter
`timescale 1ns/1ps
//
// Operation
// - Snapshot meaningful only in external timing
// - Cycle snapshot low 06, high 07
// - Counter increments each oscillator cycle integrating
// - Count published at each external integration end; internal timing publishes zero
// - Reading low at 04, high 05
// - Command bit 5 selects timing mode
// - Internal integration lasts 2^m cycles
// - Half oscillator speed on ranges 0,1
// - Same oscillator behaviour in both modes
// - Three host syncs make the first measurement, two each later one
// - Third sync publishes, restarts array one
// - External cycles follow host sync spacing
// - External counter is sixteen bits wide
// - Address bit 7 write syncs, external only
// - Command bits 1:0 choose cycle count
// - Control bits 3:2 choose gain range
// - Reading refreshed after every integration
module lait_top
    import lait_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire logic [15:0] i_adc_result,
    output logic o_osc_tick,
    output logic o_integrating,
    output logic o_array_sel,
    output logic o_result_strobe,
    output logic [1:0] o_gain_range
);
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] ctrl;
        logic [15:0] counter;
        logic [15:0] reading;
        logic [15:0] snapshot;
        lait_ext_t ext;
        logic strobe;
        logic [7:0] rd;
    } lait_st_t;

    lait_st_t st_r;
    lait_st_t st_nxt;
    lait_wr_t wr;
    logic tick;
    logic ext_mode;
    logic half_speed;
    logic sync_req;
    logic [15:0] last_count;
    logic int_end;
    logic counting;

    assign wr = '{valid: i_wr_valid, addr: i_wr_addr, data: i_wr_data};
    assign ext_mode = st_r.cmd[LAIT_MODE_BIT];
    assign half_speed = ~st_r.ctrl[LAIT_GAIN_LSB + 1];
    assign sync_req = wr.valid && wr.addr[LAIT_SYNC_BIT] && ext_mode;

    lait_osc_div u_div (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_half_speed(half_speed),
        .o_tick(tick)
    );

    always_comb begin
        case (st_r.cmd[LAIT_WIDTH_LSB +: 2])
            LAIT_W_65536: last_count = LAIT_LAST_65536;
            LAIT_W_4096: last_count = LAIT_LAST_4096;
            LAIT_W_256: last_count = LAIT_LAST_256;
            LAIT_W_16: last_count = LAIT_LAST_16;
            default: last_count = LAIT_LAST_65536;
        endcase
    end

    assign counting = ext_mode ? (st_r.ext != LAIT_EXT_IDLE) : 1'b1;
    assign int_end = ext_mode ? (sync_req && st_r.ext == LAIT_EXT_ARR2)
                              : (tick && st_r.counter == last_count);

    always_comb begin
        st_nxt = st_r;
        st_nxt.strobe = 1'b0;
        if (wr.valid && !wr.addr[LAIT_SYNC_BIT]) begin
            if (wr.addr == LAIT_ADDR_CMD) begin
                st_nxt.cmd = wr.data;
            end
            if (wr.addr == LAIT_ADDR_CTRL) begin
                st_nxt.ctrl = wr.data;
            end
        end
        if (tick && counting) begin
            st_nxt.counter = st_r.counter + 16'h0001;
        end
        if (ext_mode) begin
            if (sync_req) begin
                case (st_r.ext)
                    LAIT_EXT_IDLE: begin
                        st_nxt.ext = LAIT_EXT_ARR1;
                        st_nxt.counter = LAIT_CNT_RST;
                    end
                    LAIT_EXT_ARR1: st_nxt.ext = LAIT_EXT_ARR2;
                    LAIT_EXT_ARR2: st_nxt.ext = LAIT_EXT_ARR1;
                    default: st_nxt.ext = LAIT_EXT_IDLE;
                endcase
            end
        end else begin
            st_nxt.ext = LAIT_EXT_IDLE;
        end
        if (int_end) begin
            st_nxt.reading = i_adc_result;
            // Count includes the current oscillator cycle if it ticks now
            st_nxt.snapshot = ext_mode ? st_r.counter + {15'h0000, tick} : LAIT_CNT_RST;
            st_nxt.counter = LAIT_CNT_RST;
            st_nxt.strobe = 1'b1;
        end
        if (ext_mode != st_nxt.cmd[LAIT_MODE_BIT]) begin
            st_nxt.counter = LAIT_CNT_RST;
        end
        case (i_rd_addr)
            LAIT_ADDR_CMD: st_nxt.rd = st_r.cmd;
            LAIT_ADDR_CTRL: st_nxt.rd = st_r.ctrl;
            LAIT_ADDR_READ_LO: st_nxt.rd = st_r.reading[7:0];
            LAIT_ADDR_READ_HI: st_nxt.rd = st_r.reading[15:8];
            LAIT_ADDR_SNAP_LO: st_nxt.rd = st_r.snapshot[7:0];
            LAIT_ADDR_SNAP_HI: st_nxt.rd = st_r.snapshot[15:8];
            default: st_nxt.rd = LAIT_RD_RST;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r.cmd <= LAIT_CMD_RST;
            st_r.ctrl <= LAIT_CTRL_RST;
            st_r.counter <= LAIT_CNT_RST;
            st_r.reading <= LAIT_CNT_RST;
            st_r.snapshot <= LAIT_CNT_RST;
            st_r.ext <= LAIT_EXT_IDLE;
            st_r.strobe <= 1'b0;
            st_r.rd <= LAIT_RD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rd_data = st_r.rd;
    assign o_osc_tick = tick;
    assign o_integrating = counting;
    assign o_array_sel = (st_r.ext == LAIT_EXT_ARR2);
    assign o_result_strobe = st_r.strobe;
    assign o_gain_range = st_r.ctrl[LAIT_GAIN_LSB +: 2];
endmodule

// ==== dv/lait_host_model.sv ====
// Host model issuing register and sync writes
`timescale 1ns/1ps
module lait_host_model (
    input wire logic i_clk,
    output logic o_wr_valid = 1'b0,
    output logic [7:0] o_wr_addr = 8'h00,
    output logic [7:0] o_wr_data = 8'h00
);
    task automatic wr(logic [7:0] ad, logic [7:0] dt);
        @(posedge i_clk);
        o_wr_valid <= 1'b1;
        o_wr_addr <= ad;
        o_wr_data <= dt;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        o_wr_addr <= ~ad;
        o_wr_data <= ~dt;
    endtask
    // Spacing kept far below counter capacity
    task automatic sy(int n);
        wr(8'h80, 8'h5a);
        repeat (n) @(posedge i_clk);
    endtask
endmodule

// ==== dv/lait_top_chk.sv ====
// Checker for the light converter timing block
`timescale 1ns/1ps
module lait_top_chk (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic o_osc_tick,
    input wire logic o_array_sel,
    input wire logic o_result_strobe,
    input wire logic [1:0] o_gain_range
);
    wire logic sy = i_wr_valid && i_wr_addr[7];
    wire logic cw = i_wr_valid && i_wr_addr == 8'h01;
    // Timing mode as last written, so syncs in internal timing are not expected to end anything
    logic md;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            md <= 1'b0;
        end else if (i_wr_valid && i_wr_addr == 8'h00) begin
            md <= i_wr_data[5];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    chk_tick_full: assert property (o_gain_range[1] |-> o_osc_tick) else $error("tick");
    chk_tick_half: assert property (!o_gain_range[1] && o_osc_tick ##1 $stable(o_gain_range)
        |-> !o_osc_tick) else $error("tick");
    chk_gain_set: assert property (cw |=> o_gain_range == $past(i_wr_data[3:2]))
        else $error("gain");
    chk_gain_hold: assert property (!cw |=> $stable(o_gain_range)) else $error("gain");
    chk_strobe_one: assert property (o_result_strobe |=> !o_result_strobe) else $error("strobe");
    chk_sync_done: assert property (sy && md && o_array_sel |=> o_result_strobe) else $error("end");
    chk_sync_arr1: assert property (sy && o_array_sel |=> !o_array_sel) else $error("arr");
    chk_strobe_arr: assert property (o_result_strobe |-> !o_array_sel) else $error("arr");
endmodule
bind lait_top lait_top_chk chk_u (.*);

// ==== dv/test_light_adc_integration_timing.sv ====
// Bench for the light converter timing block
`timescale 1ns/1ps
module test_light_adc_integration_timing;
    logic i_clk = 0, i_srst = 1, i_wr_valid, o_osc_tick, o_integrating, o_array_sel;
    logic o_result_strobe;
    logic [7:0] i_wr_addr, i_wr_data, i_rd_addr = 8'h04, o_rd_data;
    logic [15:0] i_adc_result = 16'h0000;
    logic [1:0] o_gain_range;
    logic [31:0] r;
    // Control, command, expected strobe spacing
    logic [31:0] rows [4] = '{32'h0003_0020, 32'h0c02_0100, 32'h0401_2000, 32'h0800_2328};
    int n_mismatch = 0, n_tests = 0, n;
    always #12.5 i_clk = ~i_clk;
    lait_host_model host_u (.i_clk(i_clk), .o_wr_valid(i_wr_valid), .o_wr_addr(i_wr_addr),
        .o_wr_data(i_wr_data));
    lait_top dut_u (.*);
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic rd16(logic [7:0] lo, logic [15:0] e, string nm);
        logic [15:0] g;
        @(posedge i_clk) i_rd_addr <= lo;
        @(posedge i_clk) i_rd_addr <= lo + 8'h01;
        #1 g[7:0] = o_rd_data;
        @(posedge i_clk) #1 g[15:8] = o_rd_data;
        chk(nm, e, g);
    endtask
    // Counts cycles up to the next strobe; none seen gives 9000
    task automatic wt(bit nn);
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (o_result_strobe !== 1'b1 && n < 9000);
        if (o_result_strobe !== 1'b1 && !nn) begin
            chk("strobe", 16'h0001, 16'h0000);
            finish_test();
        end
    endtask
    task automatic do_reset;
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
    endtask
    initial begin
        do_reset();
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge i_clk) i_adc_result <= r[31:16] ^ 16'ha5c3;
            host_u.wr(8'h01, r[31:24]);
            host_u.wr(8'h00, r[23:16]);
            chk("gain", {14'h0, r[27:26]}, {14'h0, o_gain_range});
            rd16(8'h00, r[31:16], "config");
            if (r[17:16] != 2'h0) wt(1'b0);
            wt(r[17:16] == 2'h0);
            chk("period", r[15:0], n[15:0]);
            if (r[17:16] != 2'h0) rd16(8'h04, r[31:16] ^ 16'ha5c3, "reading");
            rd16(8'h06, 16'h0000, "snapshot");
            $display("row %0d done", i);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            do_reset();
            repeat (3) host_u.sy(0);
            #1 chk("array", 16'h0000, {15'h0, o_array_sel});
            chk("strobe", 16'h0000, {15'h0, o_result_strobe});
            host_u.wr(8'h01, k ? 8'h0c : 8'h00);
            host_u.wr(8'h00, 8'h20);
            #1 chk("integrating", 16'h0000, {15'h0, o_integrating});
            host_u.sy(40);
            i_adc_result <= 16'h3c00;
            #1 chk("array", 16'h0000, {15'h0, o_array_sel});
            chk("integrating", 16'h0001, {15'h0, o_integrating});
            host_u.sy(40);
            i_adc_result <= k ? 16'h0c35 : 16'h5a0f;
            #1 chk("array", 16'h0001, {15'h0, o_array_sel});
            host_u.sy(0);
            #1 chk("strobe", 16'h0001, {15'h0, o_result_strobe});
            chk("array", 16'h0000, {15'h0, o_array_sel});
            rd16(8'h06, k ? 16'h0054 : 16'h002a, "snapshot");
            rd16(8'h04, k ? 16'h0c35 : 16'h5a0f, "reading");
            $display("external %0d done", k);
        end
        finish_test();
    end
endmodule
